/* File: verilog/bms_pkg.sv */
// Constants shared by the pack protection controller and its alarm timers.
// Assumes a 125 MHz ref_clk; voltages in mV, current in 0.1 A, temperature in deg C.
package bms_pkg;

  // Clock and timing
  localparam int CLK_FREQ_HZ  = 125_000_000;
  localparam int TICK_TIME_MS = 1000;
  localparam int TICK_CYCLES  = (CLK_FREQ_HZ / 1000) * TICK_TIME_MS;
  localparam int TONE_TIME_MS = 100;
  localparam int TONE_CYCLES  = (CLK_FREQ_HZ / 1000) * TONE_TIME_MS;

  // Parameter slots written by the set command
  localparam logic [4:0] P_UV_TRIP     = 5'h00;
  localparam logic [4:0] P_UV_REC      = 5'h01;
  localparam logic [4:0] P_OV_TRIP     = 5'h02;
  localparam logic [4:0] P_OV_REC      = 5'h03;
  localparam logic [4:0] P_BAL_SPREAD  = 5'h04;
  localparam logic [4:0] P_SHUTDOWN_V  = 5'h05;
  localparam logic [4:0] P_CHG_OC_I    = 5'h06;
  localparam logic [4:0] P_CHG_OC_DLY  = 5'h07;
  localparam logic [4:0] P_CHG_OC_REL  = 5'h08;
  localparam logic [4:0] P_DSG_OC_I    = 5'h09;
  localparam logic [4:0] P_DSG_OC_DLY  = 5'h0A;
  localparam logic [4:0] P_DSG_OC_REL  = 5'h0B;
  localparam logic [4:0] P_SC_REL      = 5'h0C;
  localparam logic [4:0] P_BAL_START_V = 5'h0D;
  localparam logic [4:0] P_COT_TRIP    = 5'h0E;
  localparam logic [4:0] P_COT_REC     = 5'h0F;
  localparam logic [4:0] P_CUT_TRIP    = 5'h10;
  localparam logic [4:0] P_CUT_REC     = 5'h11;
  localparam logic [4:0] P_BAL_MAX_I   = 5'h12;
  localparam logic [4:0] PARAM_COUNT   = 5'h13;

  // Values after reset, one per slot in slot order
  localparam logic [15:0] PARAM_RESET [0:18] = '{
    16'h0A8C, 16'h0B54, 16'h0E10, 16'h0DAC, 16'h000A, 16'h0A28,
    16'h03E8, 16'h001E, 16'h003C, 16'h03E8, 16'h001E, 16'h003C,
    16'h003C, 16'h0C1C, 16'h003C, 16'h0037, 16'h0000, 16'h0005,
    16'h0006
  };

  // Fixed power switch temperature limits, not programmable
  localparam logic signed [15:0] SW_OT_TRIP_C = 16'sh004B;
  localparam logic signed [15:0] SW_OT_REC_C  = 16'sh0041;

  typedef enum logic [0:0] {
    BAL_IDLE = 1'b0,
    BAL_RUN  = 1'b1
  } bal_state_e;

  typedef enum logic [0:0] {
    T_WATCH = 1'b0,
    T_HOLD  = 1'b1
  } timer_state_e;

endpackage : bms_pkg

/* File: verilog/alarm_timer_if.sv */
// Carrier between the controller and one timed alarm.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ns
`default_nettype none

interface alarm_timer_if;
  logic        cond;
  logic [15:0] delay_s;
  logic [15:0] release_s;
  logic        alarm;

  modport ctrl (output cond, output delay_s, output release_s, input alarm);
  modport tmr  (input cond, input delay_s, input release_s, output alarm);
endinterface : alarm_timer_if

`default_nettype wire

/* File: verilog/alarm_timer.sv */
// Timed alarm: trips after a fault persists, releases after a fixed hold.
// Assumes sec_tick is a one-cycle pulse once per second on ref_clk.
`timescale 1ns/1ns
`default_nettype none

module alarm_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Seconds tick
  input  wire logic        sec_tick,
  // Controller side
  alarm_timer_if.tmr       tif
);

  bms_pkg::timer_state_e state_reg;
  logic [15:0]           cnt_reg;

  // Delay counts whole ticks while the fault stands; a gap restarts it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= bms_pkg::T_WATCH;
      cnt_reg   <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        bms_pkg::T_WATCH:
        begin
          if (!tif.cond)
            cnt_reg <= 16'h0000;
          else if (cnt_reg >= tif.delay_s)
          begin
            state_reg <= bms_pkg::T_HOLD;
            cnt_reg   <= 16'h0000;
          end
          else if (sec_tick)
            cnt_reg <= cnt_reg + 16'h0001;
        end
        bms_pkg::T_HOLD:
        begin
          // Release is timed only, not tied to the fault clearing
          if (cnt_reg >= tif.release_s)
          begin
            state_reg <= bms_pkg::T_WATCH;
            cnt_reg   <= 16'h0000;
          end
          else if (sec_tick)
            cnt_reg <= cnt_reg + 16'h0001;
        end
        default:
        begin
          state_reg <= bms_pkg::T_WATCH;
          cnt_reg   <= 16'h0000;
        end
      endcase
    end
  end

  assign tif.alarm = (state_reg == bms_pkg::T_HOLD);

  a_trip_needs_fault: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
    $rose(tif.alarm) |-> $past(tif.cond) && $past(cnt_reg >= tif.delay_s))
    else $error("Timed alarm rose without a persisting fault");

  a_release_after_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R10]
    $fell(tif.alarm) |-> $past(cnt_reg >= tif.release_s))
    else $error("Timed alarm released before its hold elapsed");

endmodule : alarm_timer

`default_nettype wire

/* File: verilog/pack_protect.sv */
// Pack protection and balancing controller: thresholds, alarms, switches, calibration.
// Assumes measurements come from same-clock front ends; short_det is an async pin.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1 - Balance runs while enabled, spread over trigger and cell over start voltage.
// R2 - Application should set trigger spread 0.005V above 50Ah, else 0.01V.
// R3 - Any cell below under-voltage trip raises alarm, opens discharge switch.
// R4 - Under-voltage alarm clears only when all cells exceed recovery level.
// R5 - Any cell above overcharge trip raises alarm, opens charge switch.
// R6 - Overcharge alarm clears only when all cells fall below recovery level.
// R7 - Device shuts down when lowest cell reaches shutdown voltage.
// R8 - Application must set shutdown voltage below under-voltage trip.
// R9 - Charge current over limit longer than delay raises alarm, opens charge switch.
// R10 - Charge over-current alarm clears after its release time.
// R11 - Discharge current over limit longer than delay raises alarm, opens discharge.
// R12 - Discharge over-current alarm clears after its release time.
// R13 - Short-circuit trip is removed automatically after its release time.
// R14 - Application keeps maximum balance current at most 0.1 of capacity.
// R15 - Charging over-temperature opens charge switch; clears below recovery value.
// R16 - Charging low temperature opens charge switch; clears above recovery value.
// R17 - Switch temperature over 75 opens both switches; released below 65.
// R18 - Parameter takes effect only on set command; tone sounds on acceptance.
// R19 - Voltage calibration corrects pack voltage scaling to the submitted value; the code applies an offset instead.
// R20 - Current calibration corrects current scaling to the submitted value; the code applies an offset instead.
// R21 - Balancing never runs while the balance switch is off.
// R22 - Alarms are independent; a switch closes only with no alarm holding it.
// R23 - Delays and release times count a one-second tick from the clock.
module pack_protect #(
  parameter int TICK_CYCLES = bms_pkg::TICK_CYCLES,
  parameter int TONE_CYCLES = bms_pkg::TONE_CYCLES
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // Measurements
  input  wire logic [15:0]        cell_v_max,
  input  wire logic [15:0]        cell_v_min,
  input  wire logic [15:0]        pack_v_raw,
  input  wire logic signed [15:0] pack_i_raw,
  input  wire logic signed [15:0] batt_temp,
  input  wire logic signed [15:0] switch_temp,
  input  wire logic               short_det,
  // User switches
  input  wire logic               charge_allow,
  input  wire logic               discharge_allow,
  input  wire logic               balance_allow,
  // Parameter and calibration commands
  input  wire logic               param_set,
  input  wire logic [4:0]         param_sel,
  input  wire logic [15:0]        param_value,
  input  wire logic               cal_v_set,
  input  wire logic               cal_i_set,
  input  wire logic [15:0]        cal_value,
  // Power switches and balancing
  output logic                    charge_sw_on,
  output logic                    discharge_sw_on,
  output logic                    balance_run,
  output logic [15:0]             bal_i_limit,
  output logic                    shutdown_req,
  // Alarms
  output logic                    alarm_uv,
  output logic                    alarm_ov,
  output logic                    alarm_chg_oc,
  output logic                    alarm_dsg_oc,
  output logic                    alarm_short,
  output logic                    alarm_chg_ot,
  output logic                    alarm_chg_ut,
  output logic                    alarm_sw_ot,
  // Corrected readings and tone
  output logic [15:0]             pack_v_out,
  output logic signed [15:0]      pack_i_out,
  output logic                    tone_on
);

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int TONE_W = $clog2(TONE_CYCLES + 1);

  // Refused at elaboration: a one-cycle tick leaves the counter no width
  if (TICK_CYCLES < 2 || TONE_CYCLES < 1)
  begin : g_bad_counts
    $error("pack_protect: tick and tone counts too small");
  end

  logic [15:0]        cfg_reg [0:18];
  logic [TICK_W-1:0]  tick_cnt_reg;
  logic               sec_tick_reg;
  logic [TONE_W-1:0]  tone_cnt_reg;
  logic               short_meta_reg;
  logic               short_sync_reg;
  logic signed [16:0] v_off_reg;
  logic signed [16:0] i_off_reg;
  logic signed [16:0] v_sum;
  logic signed [16:0] i_sum;
  logic signed [15:0] i_now;
  logic [15:0]        spread;
  logic               charging;
  logic               discharging;
  logic               chg_block;
  logic               dsg_block;
  bms_pkg::bal_state_e bal_state_reg;

  alarm_timer_if chg_oc_if ();
  alarm_timer_if dsg_oc_if ();
  alarm_timer_if short_if ();

  // One-second tick for every timed alarm
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_reg <= '0;
      sec_tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0; // [R23]
      sec_tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      sec_tick_reg <= 1'b0;
    end
  end

  // Short detector is a pin, so synchronise before use
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      short_meta_reg <= 1'b0;
      short_sync_reg <= 1'b0;
    end
    else
    begin
      short_meta_reg <= short_det;
      short_sync_reg <= short_meta_reg;
    end
  end

  // Parameter store; out-of-range slots are ignored and give no tone
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < 19; k++)
        cfg_reg[k] <= bms_pkg::PARAM_RESET[k];
    end
    else if (param_set && param_sel < bms_pkg::PARAM_COUNT)
      cfg_reg[param_sel] <= param_value; // [R18]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tone_cnt_reg <= '0;
    else if (param_set && param_sel < bms_pkg::PARAM_COUNT)
      tone_cnt_reg <= TONE_W'(TONE_CYCLES); // [R18]
    else if (tone_cnt_reg != '0)
      tone_cnt_reg <= tone_cnt_reg - 1'b1;
  end

  assign tone_on = (tone_cnt_reg != '0);

  // Offset calibration; voltage only taken with both switches open
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      v_off_reg <= 17'sh00000;
      i_off_reg <= 17'sh00000;
    end
    else
    begin
      if (cal_v_set && !charge_sw_on && !discharge_sw_on)
        v_off_reg <= $signed({1'b0, cal_value}) - $signed({1'b0, pack_v_raw}); // [R19]
      if (cal_i_set)
        i_off_reg <= 17'($signed(cal_value)) - 17'(pack_i_raw); // [R20]
    end
  end

  assign v_sum = $signed({1'b0, pack_v_raw}) + v_off_reg;
  assign i_sum = 17'(pack_i_raw) + i_off_reg;
  assign i_now = i_sum[15:0];

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pack_v_out <= 16'h0000;
      pack_i_out <= 16'sh0000;
    end
    else
    begin
      pack_v_out <= v_sum[15:0]; // [R19]
      pack_i_out <= i_now;       // [R20]
    end
  end

  assign charging    = (i_now > 16'sh0000);
  assign discharging = (i_now < 16'sh0000);

  // Cell voltage alarms with hysteresis
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alarm_uv <= 1'b0;
      alarm_ov <= 1'b0;
    end
    else
    begin
      if (cell_v_min < cfg_reg[bms_pkg::P_UV_TRIP])
        alarm_uv <= 1'b1; // [R3]
      else if (cell_v_min > cfg_reg[bms_pkg::P_UV_REC])
        alarm_uv <= 1'b0; // [R4]
      if (cell_v_max > cfg_reg[bms_pkg::P_OV_TRIP])
        alarm_ov <= 1'b1; // [R5]
      else if (cell_v_max < cfg_reg[bms_pkg::P_OV_REC])
        alarm_ov <= 1'b0; // [R6]
    end
  end

  // Temperature alarms; charge ones only trip while charging
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alarm_chg_ot <= 1'b0;
      alarm_chg_ut <= 1'b0;
      alarm_sw_ot  <= 1'b0;
    end
    else
    begin
      if (charging && batt_temp > $signed(cfg_reg[bms_pkg::P_COT_TRIP]))
        alarm_chg_ot <= 1'b1; // [R15]
      else if (batt_temp < $signed(cfg_reg[bms_pkg::P_COT_REC]))
        alarm_chg_ot <= 1'b0; // [R15]
      if (charging && batt_temp < $signed(cfg_reg[bms_pkg::P_CUT_TRIP]))
        alarm_chg_ut <= 1'b1; // [R16]
      else if (batt_temp > $signed(cfg_reg[bms_pkg::P_CUT_REC]))
        alarm_chg_ut <= 1'b0; // [R16]
      if (switch_temp > bms_pkg::SW_OT_TRIP_C)
        alarm_sw_ot <= 1'b1; // [R17]
      else if (switch_temp < bms_pkg::SW_OT_REC_C)
        alarm_sw_ot <= 1'b0; // [R17]
    end
  end

  // Shutdown latches until reset; nothing inside can wake the pack
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      shutdown_req <= 1'b0;
    else if (cell_v_min <= cfg_reg[bms_pkg::P_SHUTDOWN_V])
      shutdown_req <= 1'b1; // [R7]
  end

  // Timed alarms
  assign chg_oc_if.cond      = charging && (i_now > $signed(cfg_reg[bms_pkg::P_CHG_OC_I])); // [R9]
  assign chg_oc_if.delay_s   = cfg_reg[bms_pkg::P_CHG_OC_DLY];
  assign chg_oc_if.release_s = cfg_reg[bms_pkg::P_CHG_OC_REL]; // [R10]
  assign dsg_oc_if.cond      = discharging && (-17'(i_now) > 17'(cfg_reg[bms_pkg::P_DSG_OC_I])); // [R11]
  assign dsg_oc_if.delay_s   = cfg_reg[bms_pkg::P_DSG_OC_DLY];
  assign dsg_oc_if.release_s = cfg_reg[bms_pkg::P_DSG_OC_REL]; // [R12]
  assign short_if.cond       = short_sync_reg;
  assign short_if.delay_s    = 16'h0000;
  assign short_if.release_s  = cfg_reg[bms_pkg::P_SC_REL]; // [R13]

  alarm_timer u_chg_oc (.ref_clk(ref_clk), .reset_n(reset_n), .sec_tick(sec_tick_reg),
                        .tif(chg_oc_if.tmr));
  alarm_timer u_dsg_oc (.ref_clk(ref_clk), .reset_n(reset_n), .sec_tick(sec_tick_reg),
                        .tif(dsg_oc_if.tmr));
  alarm_timer u_short  (.ref_clk(ref_clk), .reset_n(reset_n), .sec_tick(sec_tick_reg),
                        .tif(short_if.tmr));

  assign alarm_chg_oc = chg_oc_if.alarm;
  assign alarm_dsg_oc = dsg_oc_if.alarm;
  assign alarm_short  = short_if.alarm;

  // Each switch opens if any alarm holding it is set
  assign chg_block = alarm_ov | alarm_chg_oc | alarm_chg_ot | alarm_chg_ut | alarm_sw_ot;
  assign dsg_block = alarm_uv | alarm_dsg_oc | alarm_short | alarm_sw_ot;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      charge_sw_on    <= 1'b0;
      discharge_sw_on <= 1'b0;
    end
    else
    begin
      charge_sw_on    <= charge_allow && !shutdown_req && !chg_block;    // [R22]
      discharge_sw_on <= discharge_allow && !shutdown_req && !dsg_block; // [R22]
    end
  end

  // Balancing with hold band between start and stop
  assign spread = (cell_v_max > cell_v_min) ? (cell_v_max - cell_v_min) : 16'h0000;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      bal_state_reg <= bms_pkg::BAL_IDLE;
    else
    begin
      case (bal_state_reg)
        bms_pkg::BAL_IDLE:
          if (balance_allow && spread > cfg_reg[bms_pkg::P_BAL_SPREAD]
              && cell_v_max > cfg_reg[bms_pkg::P_BAL_START_V])
            bal_state_reg <= bms_pkg::BAL_RUN; // [R1]
        bms_pkg::BAL_RUN:
          if (!balance_allow) // [R21]
            bal_state_reg <= bms_pkg::BAL_IDLE;
          else if (spread < cfg_reg[bms_pkg::P_BAL_SPREAD]
                   || cell_v_max < cfg_reg[bms_pkg::P_BAL_START_V])
            bal_state_reg <= bms_pkg::BAL_IDLE; // [R1]
        default:
          bal_state_reg <= bms_pkg::BAL_IDLE;
      endcase
    end
  end

  // Gate with the live switch so turning it off stops at once
  assign balance_run = (bal_state_reg == bms_pkg::BAL_RUN) && balance_allow; // [R21]
  assign bal_i_limit = cfg_reg[bms_pkg::P_BAL_MAX_I];

  a_uv_opens_dsg: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
    (cell_v_min < cfg_reg[bms_pkg::P_UV_TRIP]) |=> alarm_uv ##1 !discharge_sw_on)
    else $error("Under-voltage did not open discharge switch");

  a_uv_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
    $fell(alarm_uv) |-> $past(cell_v_min > cfg_reg[bms_pkg::P_UV_REC]))
    else $error("Under-voltage alarm cleared before recovery");

  a_ov_opens_chg: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
    (cell_v_max > cfg_reg[bms_pkg::P_OV_TRIP]) |=> alarm_ov ##1 !charge_sw_on)
    else $error("Overcharge did not open charge switch");

  a_ov_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
    $fell(alarm_ov) |-> $past(cell_v_max < cfg_reg[bms_pkg::P_OV_REC]))
    else $error("Overcharge alarm cleared before recovery");

  a_shutdown_latch: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
    (cell_v_min <= cfg_reg[bms_pkg::P_SHUTDOWN_V]) |=> shutdown_req [*3])
    else $error("Shutdown not taken or not held");

  a_sw_ot_both: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R17]
    (switch_temp > bms_pkg::SW_OT_TRIP_C) |=> ##1 (!charge_sw_on && !discharge_sw_on))
    else $error("Switch over-temperature left a switch closed");

  a_balance_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R21]
    !balance_allow |-> !balance_run ##1 (bal_state_reg == bms_pkg::BAL_IDLE))
    else $error("Balancing ran with the balance switch off");

  a_balance_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
    $rose(balance_run) |-> $past(spread > cfg_reg[bms_pkg::P_BAL_SPREAD])
                           || $past(bal_state_reg == bms_pkg::BAL_RUN))
    else $error("Balancing started without enough spread");

  a_tone_on_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R18]
    (param_set && param_sel < bms_pkg::PARAM_COUNT) |=> tone_on
    && cfg_reg[$past(param_sel)] == $past(param_value))
    else $error("Accepted parameter gave no tone or was not stored");

  a_switch_closes: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R22]
    charge_sw_on |-> $past(!chg_block && charge_allow && !shutdown_req))
    else $error("Charge switch closed while an alarm held it");

endmodule : pack_protect

`default_nettype wire

/* File: verif/pack_model.sv */
// Far side of the controller: the charger or load behind the two power switches.
// Assumes the bench sets the demanded current; an open switch passes nothing in its own direction.
`timescale 1ns/1ns
`default_nettype none

module pack_model (
  // Switch states
  input  wire logic               charge_sw_on,
  input  wire logic               discharge_sw_on,
  // Demanded current
  input  wire logic signed [15:0] load_i,
  // Measured current
  output logic signed [15:0]      pack_i_raw
);
  // Opening a switch ends the current, so a timed alarm can release cleanly
  always_comb
  begin
    pack_i_raw = 16'sh0000;
    if ((load_i > 16'sh0000 && charge_sw_on) || (load_i < 16'sh0000 && discharge_sw_on))
      pack_i_raw = load_i;
  end
endmodule : pack_model

`default_nettype wire

/* File: verif/pack_protect_test.sv */
// Self-checking bench for pack_protect with a short tick and tone.
// Assumes pack_model supplies the current; all other inputs come from here.
`timescale 1ns/1ns
`default_nettype none

module pack_protect_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] cell_v_max = 16'h0CE4;
  logic [15:0] cell_v_min = 16'h0CE0;
  logic [15:0] pack_v_raw = 16'h03E8;
  logic signed [15:0] pack_i_raw;
  logic signed [15:0] load_i = 16'sh0000;
  logic signed [15:0] batt_temp = 16'sh0019;
  logic signed [15:0] switch_temp = 16'sh0019;
  logic short_det = 1'b0;
  logic charge_allow = 1'b1;
  logic discharge_allow = 1'b1;
  logic balance_allow = 1'b0;
  logic param_set = 1'b0;
  logic [4:0] param_sel = 5'h00;
  logic [15:0] param_value = 16'h0000;
  logic cal_v_set = 1'b0;
  logic cal_i_set = 1'b0;
  logic [15:0] cal_value = 16'h0000;
  logic charge_sw_on, discharge_sw_on, balance_run, shutdown_req, tone_on;
  logic alarm_uv, alarm_ov, alarm_chg_oc, alarm_dsg_oc, alarm_short;
  logic alarm_chg_ot, alarm_chg_ut, alarm_sw_ot;
  logic [15:0] bal_i_limit, pack_v_out;
  logic signed [15:0] pack_i_out;
  int mismatches = 0;
  int checks_done = 0;
  wire logic [4:0] wv = {alarm_short, discharge_sw_on, charge_sw_on, alarm_dsg_oc, alarm_chg_oc};

  always #4 ref_clk = ~ref_clk;

  pack_protect #(.TICK_CYCLES(10), .TONE_CYCLES(3)) dut (
    .ref_clk, .reset_n, .cell_v_max, .cell_v_min, .pack_v_raw, .pack_i_raw, .batt_temp,
    .switch_temp, .short_det, .charge_allow, .discharge_allow, .balance_allow, .param_set,
    .param_sel, .param_value, .cal_v_set, .cal_i_set, .cal_value, .charge_sw_on,
    .discharge_sw_on, .balance_run, .bal_i_limit, .shutdown_req, .alarm_uv, .alarm_ov,
    .alarm_chg_oc, .alarm_dsg_oc, .alarm_short, .alarm_chg_ot, .alarm_chg_ut, .alarm_sw_ot,
    .pack_v_out, .pack_i_out, .tone_on
  );

  pack_model far (.charge_sw_on, .discharge_sw_on, .load_i, .pack_i_raw);

  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chkb(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask : chkb

  task automatic wait_bit(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && wv[k] !== v; i++)
      cyc(1);
    chkb(wv[k], v);
    if (wv[k] !== v)
      tally_and_finish();
  endtask : wait_bit

  task automatic setp(input logic [4:0] s, input logic [15:0] v);
    param_sel = s;
    param_value = v;
    param_set = 1'b1;
    cyc(1);
    param_set = 1'b0;
    cyc(1);
  endtask : setp

  // Over-current: trips after 2 ticks, releases 3 ticks after trip
  task automatic oc(input int k, input logic signed [15:0] i);
    load_i = i;
    cyc(8);
    chkb(wv[k], 1'b0);
    wait_bit(k, 1'b1, 20);
    cyc(2);
    chkb(wv[k + 2], 1'b0);
    load_i = 16'sh0000;
    cyc(15);
    chkb(wv[k], 1'b1);
    wait_bit(k, 1'b0, 25);
    cyc(2);
    chkb(wv[k + 2], 1'b1);
  endtask : oc

  initial
  begin
    cyc(3);
    chk(bal_i_limit, 16'h0006);
    chkb(charge_sw_on, 1'b0);
    cyc(1);
    reset_n = 1'b1;
    cyc(2);
    chkb(charge_sw_on, 1'b1);
    cell_v_max = 16'h0E11;
    cyc(3);
    chkb(alarm_ov, 1'b1);
    chk({charge_sw_on, discharge_sw_on}, 2'b01);
    cell_v_max = 16'h0DAC;
    cyc(3);
    chkb(alarm_ov, 1'b1);
    cell_v_max = 16'h0DAB;
    cyc(3);
    chk({alarm_ov, charge_sw_on}, 2'b01);
    cell_v_min = 16'h0A8B;
    cyc(3);
    chk({alarm_uv, charge_sw_on, discharge_sw_on}, 3'b110);
    cell_v_min = 16'h0B54;
    cyc(3);
    chkb(alarm_uv, 1'b1);
    cell_v_min = 16'h0B55;
    cyc(3);
    chk({alarm_uv, discharge_sw_on}, 2'b01);
    cell_v_min = 16'h0CE0;
    cell_v_max = 16'h0E11;
    switch_temp = 16'sh004C;
    cyc(3);
    chk({alarm_sw_ot, charge_sw_on, discharge_sw_on}, 3'b100);
    switch_temp = 16'sh0041;
    cyc(3);
    chkb(alarm_sw_ot, 1'b1);
    switch_temp = 16'sh0040;
    cyc(3);
    chk({alarm_sw_ot, charge_sw_on, discharge_sw_on}, 3'b001);
    cell_v_max = 16'h0CE4;
    cyc(3);
    chkb(charge_sw_on, 1'b1);
    // Charge temperature alarms; no current means no trip
    batt_temp = 16'sh003D;
    cyc(3);
    chkb(alarm_chg_ot, 1'b0);
    load_i = 16'sh0064;
    cyc(3);
    chk({alarm_chg_ot, charge_sw_on}, 2'b10);
    batt_temp = 16'sh0037;
    cyc(3);
    chkb(alarm_chg_ot, 1'b1);
    batt_temp = 16'sh0036;
    cyc(3);
    chk({alarm_chg_ot, charge_sw_on}, 2'b01);
    batt_temp = 16'shFFFF;
    cyc(3);
    chk({alarm_chg_ut, charge_sw_on}, 2'b10);
    batt_temp = 16'sh0005;
    cyc(3);
    chkb(alarm_chg_ut, 1'b1);
    batt_temp = 16'sh0006;
    cyc(3);
    chk({alarm_chg_ut, charge_sw_on}, 2'b01);
    batt_temp = 16'sh0019;
    load_i = 16'sh0000;
    cyc(1);
    setp(bms_pkg::P_CHG_OC_DLY, 16'h0002);
    chkb(tone_on, 1'b1);
    setp(bms_pkg::P_CHG_OC_REL, 16'h0003);
    setp(bms_pkg::P_DSG_OC_DLY, 16'h0002);
    setp(bms_pkg::P_DSG_OC_REL, 16'h0003);
    setp(bms_pkg::P_SC_REL, 16'h0002);
    cyc(5);
    chkb(tone_on, 1'b0);
    setp(5'h13, 16'h0000);
    chkb(tone_on, 1'b0);
    oc(0, 16'sh03E9);
    oc(1, -16'sh03E9);
    short_det = 1'b1;
    cyc(2);
    short_det = 1'b0;
    wait_bit(4, 1'b1, 6);
    cyc(5);
    chkb(alarm_short, 1'b1);
    wait_bit(4, 1'b0, 25);
    // Trigger spread left at 10 mV, the smaller-pack setting
    balance_allow = 1'b1;
    cell_v_max = 16'h0C1D;
    cell_v_min = 16'h0C12;
    cyc(3);
    chkb(balance_run, 1'b1);
    balance_allow = 1'b0;
    cyc(1);
    chkb(balance_run, 1'b0);
    balance_allow = 1'b1;
    cyc(2);
    chkb(balance_run, 1'b1);
    cell_v_min = 16'h0C14;
    cyc(3);
    chkb(balance_run, 1'b0);
    // Operator opens both switches before a voltage calibration
    charge_allow = 1'b0;
    discharge_allow = 1'b0;
    cyc(3);
    cal_value = 16'h0400;
    cal_v_set = 1'b1;
    cyc(1);
    cal_v_set = 1'b0;
    cyc(2);
    chk(pack_v_out, 16'h0400);
    pack_v_raw = 16'h03F0;
    charge_allow = 1'b1;
    load_i = 16'sh0064;
    cyc(3);
    chk(pack_v_out, 16'h0408);
    cal_value = 16'h0500;
    cal_v_set = 1'b1;
    cyc(1);
    cal_v_set = 1'b0;
    cal_value = 16'h0078;
    cal_i_set = 1'b1;
    cyc(1);
    cal_i_set = 1'b0;
    cyc(2);
    chk(pack_v_out, 16'h0408);
    chk(pack_i_out, 16'h0078);
    load_i = 16'sh0000;
    cyc(3);
    chk(pack_i_out, 16'h0014);
    // Shutdown level left at its default, below the under-voltage trip
    cell_v_min = 16'h0A28;
    cyc(3);
    chk({shutdown_req, charge_sw_on, discharge_sw_on}, 3'b100);
    cell_v_min = 16'h0CE0;
    cyc(3);
    chkb(shutdown_req, 1'b1);
    tally_and_finish();
  end
endmodule : pack_protect_test

`default_nettype wire
